// [design/ovr_nco.sv]
// Summary of operation
// R1 - watch each 12-bit sample, top 8 magnitude bits
// R2 - flip MSB, take 11-bit absolute value
// R3 - most negative code saturates to 255
// R4 - flag set if any value reaches threshold
// R5 - window length is 2 to the exponent
// R6 - high flag replaces I word LSB
// R7 - low flag replaces Q word LSB
// R8 - receiver adjusts gain from the two flags
// R9 - power-down disables serial output drivers
// R10 - after power-down receiver relinks and flushes
// R11 - offset trim ignored during background calibration
// R12 - real input mixed by complex oscillator
// R13 - eight presets with free-running accumulators
// R14 - source bit 0 selects preset by pins
// R15 - source bit 1 selects preset by register
// R16 - each preset programmed independently
// R17 - frequency is word times 2^-32 times clock
// R18 - 8-bit thresholds, back-to-back held windows
// R19 - preset change mid-link gives random phase
// R20 - phase offset left-justified, added to accumulator
`timescale 1ns/10ps
`default_nettype none

module ovr_nco #(
    parameter int PRESET_N = ovr_nco_pkg::PRESETS
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic                hready,
    input  wire logic [31:0]         hwdata,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic [11:0]         sample,
    input  wire logic [2:0]          preset_select_pins,
    output ovr_nco_pkg::cplx_s       mixed,
    output logic                     serial_enable,
    output logic [7:0]               offset_applied
);

    if (PRESET_N != 8) begin : g_chk
        $error("preset count must be 8");
    end

    // ----------------------------------------------------------------
    // register file over AHB-Lite
    // ----------------------------------------------------------------
    logic [7:0]  high_limit_q, high_limit_d;
    logic [7:0]  low_limit_q, low_limit_d;
    ovr_nco_pkg::ctrl_s ctrl_q, ctrl_d;
    logic        src_q, src_d;
    logic [2:0]  preset_select_bits_q, preset_select_bits_d;
    logic [31:0] preset_freq_word_q [PRESET_N];
    logic [31:0] preset_freq_word_d [PRESET_N];
    logic [15:0] preset_phase_word_q [PRESET_N];
    logic [15:0] preset_phase_word_d [PRESET_N];
    logic        wpend_q, wpend_d;
    logic [13:0] waddr_q, waddr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic        high_limit_flag_q, low_limit_flag_q;
    logic        addr_ok;
    logic        rd_req;

    assign addr_ok = hsel && hready && htrans[1];
    assign rd_req  = addr_ok && !hwrite;

    // register writes in data phase, reads prepared in address phase
    always_comb begin
        high_limit_d         = high_limit_q;
        low_limit_d          = low_limit_q;
        ctrl_d               = ctrl_q;
        src_d                = src_q;
        preset_select_bits_d = preset_select_bits_q;
        preset_freq_word_d   = preset_freq_word_q;
        preset_phase_word_d  = preset_phase_word_q;
        wpend_d              = addr_ok && hwrite;
        waddr_d              = haddr[13:0];
        hrdata_d             = hrdata_q;
        if (wpend_q) begin
            case (waddr_q)
                ovr_nco_pkg::ADDR_LIMITS: begin
                    high_limit_d = hwdata[7:0]; // [R18]
                    low_limit_d  = hwdata[ovr_nco_pkg::POS_LOW_LIMIT +: 8];
                end
                ovr_nco_pkg::ADDR_CONTROL: begin
                    ctrl_d.pd     = hwdata[ovr_nco_pkg::POS_PD];
                    ctrl_d.bg_cal = hwdata[ovr_nco_pkg::POS_BG_CAL];
                    ctrl_d.exp    = hwdata[ovr_nco_pkg::POS_EXP +: 3];
                    ctrl_d.offset = hwdata[ovr_nco_pkg::POS_OFFSET +: 8];
                end
                ovr_nco_pkg::ADDR_SOURCE: src_d = hwdata[0];
                ovr_nco_pkg::ADDR_SELECT: preset_select_bits_d = hwdata[2:0];
                default: begin
                    // per-preset words, each on its own address
                    for (int k = 0; k < PRESET_N; k++) begin
                        if (waddr_q == ovr_nco_pkg::ADDR_FREQ0
                                + 14'(4 * k))
                            preset_freq_word_d[k] = hwdata; // [R16]
                        if (waddr_q == ovr_nco_pkg::ADDR_PHASE0
                                + 14'(4 * k))
                            preset_phase_word_d[k] = hwdata[15:0];
                    end
                end
            endcase
        end
        if (rd_req) begin
            hrdata_d = 32'h0000_0000;
            case (haddr[13:0])
                ovr_nco_pkg::ADDR_LIMITS:
                    hrdata_d = {16'h0000, low_limit_q, high_limit_q};
                ovr_nco_pkg::ADDR_CONTROL:
                    hrdata_d = {16'h0000, ctrl_q.offset, 1'b0,
                                ctrl_q.exp, 2'b00, ctrl_q.bg_cal,
                                ctrl_q.pd};
                ovr_nco_pkg::ADDR_STATUS:
                    hrdata_d = {30'h0, low_limit_flag_q,
                                high_limit_flag_q};
                ovr_nco_pkg::ADDR_SOURCE:
                    hrdata_d = {31'h0, src_q};
                ovr_nco_pkg::ADDR_SELECT:
                    hrdata_d = {29'h0, preset_select_bits_q};
                default: begin
                    for (int k = 0; k < PRESET_N; k++) begin
                        if (haddr[13:0] == ovr_nco_pkg::ADDR_FREQ0
                                + 14'(4 * k))
                            hrdata_d = preset_freq_word_q[k];
                        if (haddr[13:0] == ovr_nco_pkg::ADDR_PHASE0
                                + 14'(4 * k))
                            hrdata_d = {16'h0000, preset_phase_word_q[k]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_limit_q         <= ovr_nco_pkg::RST_HIGH_LIMIT;
            low_limit_q          <= ovr_nco_pkg::RST_LOW_LIMIT;
            ctrl_q               <= '0;
            src_q                <= 1'b0;
            preset_select_bits_q <= 3'h0;
            for (int k = 0; k < PRESET_N; k++) begin
                preset_freq_word_q[k]  <= ovr_nco_pkg::RST_FREQ;
                preset_phase_word_q[k] <= ovr_nco_pkg::RST_PHASE;
            end
            wpend_q              <= 1'b0;
            waddr_q              <= 14'h0000;
            hrdata_q             <= 32'h0000_0000;
        end else begin
            high_limit_q         <= high_limit_d;
            low_limit_q          <= low_limit_d;
            ctrl_q               <= ctrl_d;
            src_q                <= src_d;
            preset_select_bits_q <= preset_select_bits_d;
            preset_freq_word_q   <= preset_freq_word_d;
            preset_phase_word_q  <= preset_phase_word_d;
            wpend_q              <= wpend_d;
            waddr_q              <= waddr_d;
            hrdata_q             <= hrdata_d;
        end
    end

    // zero wait state, always OKAY
    assign hrdata    = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ----------------------------------------------------------------
    // over-range monitor
    // ----------------------------------------------------------------
    logic [11:0] twos;
    logic [10:0] mag;
    logic [7:0]  top8;
    logic [7:0]  win_cnt_q, win_cnt_d;
    logic        hit_hi_q, hit_hi_d, hit_lo_q, hit_lo_d;
    logic        high_limit_flag_d, low_limit_flag_d;
    logic        win_end;

    // offset binary to two's complement, saturating magnitude
    always_comb begin
        twos = {~sample[11], sample[10:0]}; // [R2]
        if (twos == 12'h800)
            mag = 11'h7ff; // [R3]
        else if (twos[11])
            mag = 11'((~twos) + 12'h001); // [R2]
        else
            mag = twos[10:0];
        top8 = mag[10:3]; // [R1]
    end

    // windows of 2^exp samples, back to back
    always_comb begin
        win_end = (win_cnt_q >= 8'((9'h001 << ctrl_q.exp) - 9'h001)); // [R5]
        win_cnt_d = win_end ? 8'h00 : win_cnt_q + 8'h01;
        high_limit_flag_d = high_limit_flag_q;
        low_limit_flag_d  = low_limit_flag_q;
        hit_hi_d = hit_hi_q || (top8 >= high_limit_q);
        hit_lo_d = hit_lo_q || (top8 >= low_limit_q);
        if (win_end) begin
            high_limit_flag_d = hit_hi_d; // [R4]
            low_limit_flag_d  = hit_lo_d; // [R4]
            hit_hi_d = 1'b0;
            hit_lo_d = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win_cnt_q         <= 8'h00;
            hit_hi_q          <= 1'b0;
            hit_lo_q          <= 1'b0;
            high_limit_flag_q <= 1'b0;
            low_limit_flag_q  <= 1'b0;
        end else begin
            win_cnt_q         <= win_cnt_d;
            hit_hi_q          <= hit_hi_d;
            hit_lo_q          <= hit_lo_d;
            high_limit_flag_q <= high_limit_flag_d; // [R18]
            low_limit_flag_q  <= low_limit_flag_d;
        end
    end

    // ----------------------------------------------------------------
    // oscillator and mixer
    // ----------------------------------------------------------------
    logic [31:0] phase [PRESET_N];
    logic [2:0]  active;
    logic [1:0]  quad;
    logic signed [11:0] s_in;
    logic signed [11:0] cos_v, sin_v;
    ovr_nco_pkg::cplx_s mixed_d, mixed_q;
    logic        serial_enable_q, serial_enable_d;
    logic [7:0]  offset_q, offset_d;

    for (genvar g = 0; g < PRESET_N; g++) begin : g_acc
        preset_accum u_acc (
            .hclk       (hclk),
            .hresetn    (hresetn),
            .freq_word  (preset_freq_word_q[g]),
            .phase_word (preset_phase_word_q[g]),
            .phase      (phase[g])
        ); // [R13]
    end

    // preset choice and coarse quadrant mixing
    always_comb begin
        active = src_q ? preset_select_bits_q // [R15]
                       : preset_select_pins; // [R14]
        quad   = phase[active][31:30];
        s_in   = $signed({~sample[11], sample[10:0]});
        case (quad)
            2'd0:    begin cos_v = s_in;            sin_v = 12'sh000; end
            2'd1:    begin cos_v = 12'sh000;        sin_v = -s_in;    end
            2'd2:    begin cos_v = -s_in;           sin_v = 12'sh000; end
            default: begin cos_v = 12'sh000;        sin_v = s_in;     end
        endcase
        // sample times exp(-j phase), flags in the LSBs
        mixed_d.i_word = {cos_v, 3'b000, high_limit_flag_d}; // [R12] [R6]
        mixed_d.q_word = {sin_v, 3'b000, low_limit_flag_d}; // [R12] [R7]
        serial_enable_d = !ctrl_q.pd; // [R9]
        offset_d = ctrl_q.bg_cal ? 8'h00 : ctrl_q.offset; // [R11]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mixed_q         <= '0;
            serial_enable_q <= 1'b0;
            offset_q        <= 8'h00;
        end else begin
            mixed_q         <= mixed_d;
            serial_enable_q <= serial_enable_d;
            offset_q        <= offset_d;
        end
    end

    assign mixed          = mixed_q;
    assign serial_enable  = serial_enable_q;
    assign offset_applied = offset_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_i_flag;
        @(posedge hclk) disable iff (!hresetn)
        ##1 mixed.i_word[0] == high_limit_flag_q;
    endproperty
    a_i_flag: assert property (p_i_flag) else $error("I lsb not high flag"); // [R6]
    property p_q_flag;
        @(posedge hclk) disable iff (!hresetn)
        ##1 mixed.q_word[0] == low_limit_flag_q;
    endproperty
    a_q_flag: assert property (p_q_flag) else $error("Q lsb not low flag"); // [R7]
    property p_pd;
        @(posedge hclk) disable iff (!hresetn)
        ctrl_q.pd |=> !serial_enable;
    endproperty
    a_pd: assert property (p_pd) else $error("drivers on in power-down"); // [R9]
    property p_bgcal;
        @(posedge hclk) disable iff (!hresetn)
        ctrl_q.bg_cal |=> offset_applied == 8'h00;
    endproperty
    a_bgcal: assert property (p_bgcal) else $error("offset used in calibration"); // [R11]
    property p_sat;
        @(posedge hclk) disable iff (!hresetn)
        sample == 12'h000 |-> top8 == 8'hff;
    endproperty
    a_sat: assert property (p_sat) else $error("negative full scale not 255"); // [R3]
    property p_hit;
        @(posedge hclk) disable iff (!hresetn)
        (win_end && top8 >= high_limit_q) |=> high_limit_flag_q;
    endproperty
    a_hit: assert property (p_hit) else $error("high flag missed"); // [R4]
    property p_win;
        @(posedge hclk) disable iff (!hresetn)
        (ctrl_q.exp == 3'h0) |-> win_end;
    endproperty
    a_win: assert property (p_win) else $error("window of one not closing"); // [R5]
    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        !win_end |=> $stable(high_limit_flag_q) && $stable(low_limit_flag_q);
    endproperty
    a_hold: assert property (p_hold) else $error("flag moved inside window"); // [R18]
    property p_src;
        @(posedge hclk) disable iff (!hresetn)
        !src_q |-> active == preset_select_pins;
    endproperty
    a_src: assert property (p_src) else $error("pins not selecting preset"); // [R14]

endmodule

`default_nettype wire

// [design/ovr_nco_pkg.sv]
package ovr_nco_pkg;

    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    // printed offsets 0x20c/0x20d are not word aligned: index * 4
    localparam logic [11:0] IDX_SOURCE   = 12'h20c;
    localparam logic [11:0] IDX_SELECT   = 12'h20d;
    localparam logic [13:0] ADDR_SOURCE  = {IDX_SOURCE, 2'b00};
    localparam logic [13:0] ADDR_SELECT  = {IDX_SELECT, 2'b00};
    localparam logic [13:0] ADDR_LIMITS  = 14'h0000;
    localparam logic [13:0] ADDR_CONTROL = 14'h0004;
    localparam logic [13:0] ADDR_STATUS  = 14'h0008;
    localparam logic [13:0] ADDR_FREQ0   = 14'h0100;
    localparam logic [13:0] ADDR_PHASE0  = 14'h0140;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int          POS_LOW_LIMIT   = 8;
    localparam int          POS_PD          = 0;
    localparam int          POS_BG_CAL      = 1;
    localparam int          POS_EXP         = 4;
    localparam int          POS_OFFSET      = 8;
    localparam logic [7:0]  RST_HIGH_LIMIT  = 8'he4;
    localparam logic [7:0]  RST_LOW_LIMIT   = 8'h40;
    localparam logic [2:0]  RST_EXP         = 3'h0;
    localparam logic [31:0] RST_FREQ        = 32'h0000_0000;
    localparam logic [15:0] RST_PHASE       = 16'h0000;
    localparam int          PRESETS         = 8;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] i_word;
        logic [15:0] q_word;
    } cplx_s;

    typedef struct packed {
        logic       pd;
        logic       bg_cal;
        logic [2:0] exp;
        logic [7:0] offset;
    } ctrl_s;

endpackage

// [design/preset_accum.sv]
`timescale 1ns/10ps
`default_nettype none

// one free-running phase accumulator with its programmed offset
module preset_accum (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [31:0] freq_word,
    input  wire logic [15:0] phase_word,
    output logic      [31:0] phase
);

    logic [31:0] acc_q;
    logic [31:0] acc_d;

    // accumulator advance, runs every sample
    always_comb begin
        acc_d = acc_q + freq_word; // [R13] [R17]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q <= 32'h0000_0000;
        end else begin
            acc_q <= acc_d;
        end
    end

    // offset left-justified into 32 bits
    assign phase = acc_q + {phase_word, 16'h0000}; // [R20]

endmodule

`default_nettype wire

// [sim/cplx_sink.sv]
`timescale 1ns/10ps
`default_nettype none

// receiving end: gain advice from flags, flush after link restart
module cplx_sink #(
    parameter int QUIET_N = 64,
    parameter int FLUSH_N = 16
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire ovr_nco_pkg::cplx_s mixed,
    input  wire logic               serial_enable,
    output logic                    gain_up,
    output logic                    gain_down,
    output logic                    flushing
);
    int   quiet_q;
    int   flush_q;
    logic en_q;

    // quiet counter on low flag, flush counter on power-up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet_q <= 0;
            flush_q <= 0;
            en_q    <= 1'b0;
        end else begin
            en_q    <= serial_enable;
            quiet_q <= mixed.q_word[0] ? 0 : quiet_q + 1;
            if (serial_enable && !en_q) begin
                flush_q <= FLUSH_N;
            end else if (flush_q != 0) begin
                flush_q <= flush_q - 1;
            end
        end
    end

    // advice outputs
    assign gain_up   = quiet_q >= QUIET_N;
    assign gain_down = mixed.i_word[0];
    assign flushing  = flush_q != 0;
endmodule
`default_nettype wire

// [sim/tb_overrange_and_nco_select.sv]
`timescale 1ns/10ps
`default_nettype none

module tb_overrange_and_nco_select;
    logic               hclk;
    logic               hresetn;
    logic               hsel;
    logic [31:0]        haddr;
    logic [1:0]         htrans;
    logic               hwrite;
    logic [2:0]         hsize;
    logic [31:0]        hwdata;
    logic [31:0]        hrdata;
    logic               hreadyout;
    logic               hresp;
    logic [11:0]        sample;
    logic [2:0]         pins;
    ovr_nco_pkg::cplx_s mixed;
    logic               serial_enable;
    logic [7:0]         offset_applied;
    logic               gain_up;
    logic               gain_down;
    logic               flushing;
    int                 n_mismatch;
    int                 checks;
    logic [31:0]        nh;
    logic [31:0]        nl;
    logic [11:0]        i0;
    logic [11:0]        q0;
    logic [11:0]        a [4];
    logic [11:0]        smp [7] = '{12'hfff, 12'hff0, 12'h800, 12'h010,
                                    12'h000, 12'ha00, 12'h600};
    logic [7:0]         mag [7] = '{8'hff, 8'hfe, 8'h00, 8'hfe,
                                    8'hff, 8'h40, 8'h40};

    ovr_nco i_dut (
        .hclk               (hclk),
        .hresetn            (hresetn),
        .hsel               (hsel),
        .haddr              (haddr),
        .htrans             (htrans),
        .hwrite             (hwrite),
        .hsize              (hsize),
        .hready             (hreadyout),
        .hwdata             (hwdata),
        .hrdata             (hrdata),
        .hreadyout          (hreadyout),
        .hresp              (hresp),
        .sample             (sample),
        .preset_select_pins (pins),
        .mixed              (mixed),
        .serial_enable      (serial_enable),
        .offset_applied     (offset_applied)
    );

    cplx_sink i_sink (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .mixed         (mixed),
        .serial_enable (serial_enable),
        .gain_up       (gain_up),
        .gain_down     (gain_down),
        .flushing      (flushing)
    );

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmp(string w, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge hclk);
    endtask

    // edge by edge until the slave is ready, bounded
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 100) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 100) begin
            n_mismatch++;
            $display("ERROR hreadyout expected 1 seen %b", hreadyout);
        end
    endtask

    task automatic bus(logic w, logic [13:0] ad, logic [31:0] wd,
                       output logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {18'h0, ad};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        d = hrdata;
    endtask

    task automatic wr(logic [13:0] ad, logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, ad, d, x);
    endtask

    task automatic rdc(string w, logic [13:0] ad, logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, ad, 32'h0, x);
        cmp(w, e, x);
    endtask

    task automatic ctl(logic pd, logic bg, logic [2:0] e, logic [7:0] o);
        wr(ovr_nco_pkg::ADDR_CONTROL, {16'h0, o, 1'b0, e, 2'b0, bg, pd});
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, tests
    // ------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // cut a hang short
    initial begin
        #(25 * 20000);
        n_mismatch++;
        finish_test();
    end

    // main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        sample = 12'h800;
        pins = 3'h0;
        n_mismatch = 0;
        checks = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc("limits", ovr_nco_pkg::ADDR_LIMITS, {16'h0,
            ovr_nco_pkg::RST_LOW_LIMIT, ovr_nco_pkg::RST_HIGH_LIMIT});
        // magnitude table at the threshold boundary, window of one
        for (int k = 0; k < 7; k++) begin
            sample <= smp[k];
            wr(ovr_nco_pkg::ADDR_LIMITS, {16'h0, mag[k] + 8'h1, mag[k]});
            tick(4);
            cmp("flags", {30'h0, mag[k] == 8'hff, 1'b1},
                {30'h0, mixed.q_word[0], mixed.i_word[0]});
            rdc("status", ovr_nco_pkg::ADDR_STATUS,
                {30'h0, mag[k] == 8'hff, 1'b1});
        end
        // low flag quiet, high flag set: receiver advice both ways
        tick(64);
        cmp("gain_up", 32'h1, gain_up);
        cmp("gain_down", 32'h1, gain_down);
        wr(ovr_nco_pkg::ADDR_LIMITS, {16'h0, ovr_nco_pkg::RST_LOW_LIMIT,
            ovr_nco_pkg::RST_HIGH_LIMIT});
        // one hit every two windows: flag high half the time
        for (int e = 0; e < 8; e++) begin
            ctl(1'b0, 1'b0, e[2:0], 8'h00);
            nh = 32'h0;
            nl = 32'h0;
            for (int i = 0; i < 10 * (1 << e) + 4; i++) begin
                @(posedge hclk);
                if (i >= 2 * (1 << e) + 4) begin
                    nh = nh + mixed.i_word[0];
                    nl = nl + mixed.q_word[0];
                end
                sample <= (i % (2 << e) == 0) ? 12'ha00 : 12'h800;
            end
            cmp("low count", 4 << e, nl);
            cmp("high count", 32'h0, nh);
        end
        ctl(1'b1, 1'b0, 3'h7, 8'h5a);
        tick(2);
        cmp("serial_enable", 32'h0, serial_enable);
        cmp("offset", 32'h5a, offset_applied);
        ctl(1'b0, 1'b1, 3'h7, 8'h5a);
        tick(3);
        cmp("serial_enable", 32'h1, serial_enable);
        cmp("offset", 32'h0, offset_applied);
        cmp("flushing", 32'h1, flushing);
        // preset choice by pins, then by register bits
        sample <= 12'h864;
        wr(ovr_nco_pkg::ADDR_PHASE0 + 14'h4, 32'h8000);
        wr(ovr_nco_pkg::ADDR_SOURCE, 32'h0);
        tick(4);
        i0 = mixed.i_word[15:4];
        q0 = mixed.q_word[15:4];
        cmp("i nonzero", 32'h1, i0 != 12'h0);
        pins <= 3'h1;
        tick(4);
        cmp("pin i", 12'(-i0), mixed.i_word[15:4]);
        cmp("pin q", 12'(-q0), mixed.q_word[15:4]);
        wr(ovr_nco_pkg::ADDR_SELECT, 32'h1);
        wr(ovr_nco_pkg::ADDR_SOURCE, 32'h1);
        pins <= 3'h0;
        tick(4);
        cmp("sel i", 12'(-i0), mixed.i_word[15:4]);
        wr(ovr_nco_pkg::ADDR_SELECT, 32'h0);
        pins <= 3'h1;
        tick(4);
        cmp("sel i", i0, mixed.i_word[15:4]);
        // quarter turn per sample on preset 3
        wr(ovr_nco_pkg::ADDR_FREQ0 + 14'hc, 32'h4000_0000);
        wr(ovr_nco_pkg::ADDR_SELECT, 32'h3);
        tick(4);
        for (int j = 0; j < 4; j++) begin
            @(posedge hclk);
            a[j] = mixed.i_word[15:4];
        end
        cmp("turn 0", 12'(-a[0]), a[2]);
        cmp("turn 1", 12'(-a[1]), a[3]);
        cmp("turn nz", 32'h1, (a[0] | a[1]) != 12'h0);
        wr(ovr_nco_pkg::ADDR_SELECT, 32'h0);
        tick(4);
        cmp("preset 0", i0, mixed.i_word[15:4]);
        // register readback
        for (int k = 0; k < 8; k++) begin
            wr(ovr_nco_pkg::ADDR_FREQ0 + 14'(4 * k), 32'h1357_9bd0 + k);
            wr(ovr_nco_pkg::ADDR_PHASE0 + 14'(4 * k), 32'h1111 * k);
        end
        for (int k = 0; k < 8; k++) begin
            rdc("freq", ovr_nco_pkg::ADDR_FREQ0 + 14'(4 * k),
                32'h1357_9bd0 + k);
            rdc("phase", ovr_nco_pkg::ADDR_PHASE0 + 14'(4 * k),
                32'h1111 * k);
        end
        rdc("source", ovr_nco_pkg::ADDR_SOURCE, 32'h1);
        wr(14'h0ffc, 32'hffff_ffff);
        rdc("unmapped", 14'h0ffc, 32'h0);
        cmp("hresp", 32'h0, hresp);
        finish_test();
    end
endmodule
`default_nettype wire
